// file: core/sldd_driver.sv
// Display driver end: shift register, strobe latch and output gating.
`default_nettype none

module sldd_driver #(
  parameter int STAGES = sldd_pkg::SLDD_STAGES
) (
  input wire logic clk,
  input wire logic rst_n,
  sldd_if.device link,
  output logic [STAGES-1:0] driver_outputs
);

  logic [2:0] sclk_sync_reg;
  logic [1:0] data_sync_reg;
  logic [1:0] strobe_sync_reg;
  logic [1:0] clear_sync_reg;
  logic [1:0] test_sync_reg;
  logic sclk_rise;
  logic [STAGES-1:0] shift_reg;
  logic [STAGES-1:0] latch_reg;
  logic sout_reg;

  // Pins pass two flops; the serial clock edge is found from flops two and three.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= '0;
      data_sync_reg <= '0;
      strobe_sync_reg <= '0;
      clear_sync_reg <= 2'h3;
      test_sync_reg <= '0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.serial_clk};
      data_sync_reg <= {data_sync_reg[0], link.serial_data};
      strobe_sync_reg <= {strobe_sync_reg[0], link.latch_strobe};
      clear_sync_reg <= {clear_sync_reg[0], link.output_clear};
      test_sync_reg <= {test_sync_reg[0], link.all_on_test};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Data path shares the sync depth with the clock, so the sampled bit is aligned with its edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[STAGES-2:0], data_sync_reg[1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_reg <= 1'b0;
    end else begin
      sout_reg <= shift_reg[STAGES-1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= '0;
    end else if (strobe_sync_reg[1]) begin
      latch_reg <= shift_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // With strobe low the latch keeps its value; outputs follow it unless clear forces zero or test forces ones.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driver_outputs <= '0;
    end else if (clear_sync_reg[1]) begin
      driver_outputs <= '0;
    end else if (test_sync_reg[1]) begin
      driver_outputs <= '1;
    end else begin
      driver_outputs <= latch_reg;
    end
  end

  assign link.serial_out = sout_reg;

endmodule : sldd_driver

`default_nettype wire

// file: core/sldd_fifo.sv
// Frame FIFO with valid and ready on both sides.
`default_nettype none

module sldd_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : sldd_fifo

`default_nettype wire

// file: core/sldd_host.sv
// Host controller: takes frames from software and shifts them out to the driver.
`default_nettype none

module sldd_host #(
  parameter int STAGES = sldd_pkg::SLDD_STAGES,
  parameter int DEPTH = sldd_pkg::SLDD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [sldd_pkg::SLDD_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  sldd_if.host link
);

  localparam int CW = 16;
  localparam logic [CW-1:0] HALF = CW'(sldd_pkg::SLDD_SCLK_HALF_CYC);
  localparam logic [CW-1:0] STRB = CW'(sldd_pkg::SLDD_STROBE_CYC);

  logic [31:0] lo_reg;
  logic [STAGES-1:0] frame;
  logic [31:0] ctrl_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [STAGES-1:0] fifo_out_data;
  logic push;
  sldd_pkg::sldd_state_t state_reg;
  logic [STAGES-1:0] shreg_reg;
  logic [6:0] bits_reg;
  logic [CW-1:0] tmr_reg;
  logic sdata_reg;
  logic sclk_reg;
  logic strobe_reg;
  logic sout_m_reg;
  logic sout_s_reg;
  logic [31:0] status_word;

  // True in a cycle that writes the register at index idx.
  function automatic logic reg_write(
    logic strobe,
    logic [sldd_pkg::SLDD_ADDR_W-1:0] at,
    logic [sldd_pkg::SLDD_ADDR_W-1:0] idx
  );
    return strobe && (at == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Writing the high word pushes the frame assembled with the low word.
  // A push into a full queue is dropped, so software checks the full flag first.
  assign frame = {wdata[STAGES-33:0], lo_reg};
  assign push = reg_write(wr, addr, sldd_pkg::SLDD_REG_FRAME_HI);
  assign fifo_pop = (state_reg == sldd_pkg::SLDD_IDLE) && fifo_out_valid;

  // The queue lets software post frames while an earlier one is still shifting.
  sldd_fifo #(
    .WIDTH(STAGES),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(frame),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_reg <= '0;
    end else if (reg_write(wr, addr, sldd_pkg::SLDD_REG_FRAME_LO)) begin
      lo_reg <= wdata;
    end
  end

  // Control resets with clear set, so the display stays blank until software unblanks it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= sldd_pkg::SLDD_CTRL_RESET;
    end else if (reg_write(wr, addr, sldd_pkg::SLDD_REG_CTRL)) begin
      ctrl_reg <= {30'h0, wdata[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output of the driver crosses in through two flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_m_reg <= 1'b0;
      sout_s_reg <= 1'b0;
    end else begin
      sout_m_reg <= link.serial_out;
      sout_s_reg <= sout_m_reg;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[sldd_pkg::SLDD_STAT_BUSY_BIT] = (state_reg != sldd_pkg::SLDD_IDLE);
    status_word[sldd_pkg::SLDD_STAT_FULL_BIT] = !fifo_in_ready;
    status_word[sldd_pkg::SLDD_STAT_EMPTY_BIT] = !fifo_out_valid;
    status_word[sldd_pkg::SLDD_STAT_SOUT_BIT] = sout_s_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        sldd_pkg::SLDD_REG_FRAME_LO: rdata <= lo_reg;
        sldd_pkg::SLDD_REG_CTRL: rdata <= ctrl_reg;
        sldd_pkg::SLDD_REG_STATUS: rdata <= status_word;
        default: rdata <= '0;
      endcase
    end else begin
      // Read data stand for one cycle only and read as zero otherwise.
      rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: data set up at low phase, clock rises mid-bit, strobe after last bit.
  // The strobe waits a full half period after the last clock fall, and the next frame
  // waits for the strobe to drop, so the driver never sees clock and strobe together.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sldd_pkg::SLDD_IDLE;
      shreg_reg <= '0;
      bits_reg <= '0;
      tmr_reg <= '0;
      sdata_reg <= 1'b0;
      sclk_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      case (state_reg)
        sldd_pkg::SLDD_IDLE: begin
          sclk_reg <= 1'b0;
          strobe_reg <= 1'b0;
          if (fifo_out_valid) begin
            // Most significant bit goes first so it ends in the last stage.
            shreg_reg <= fifo_out_data << 1;
            sdata_reg <= fifo_out_data[STAGES-1];
            bits_reg <= 7'(STAGES);
            tmr_reg <= HALF;
            state_reg <= sldd_pkg::SLDD_LOW;
          end
        end
        sldd_pkg::SLDD_LOW: begin
          if (tmr_reg > 1) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            // Bits are counted at their rising edge, so the count is zero after the last.
            sclk_reg <= 1'b1;
            tmr_reg <= HALF;
            bits_reg <= bits_reg - 1'b1;
            state_reg <= sldd_pkg::SLDD_HIGH;
          end
        end
        sldd_pkg::SLDD_HIGH: begin
          if (tmr_reg > 1) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            sclk_reg <= 1'b0;
            tmr_reg <= HALF;
            // After the last high phase the clock rests low for a gap before the strobe.
            if (bits_reg == '0) begin
              state_reg <= sldd_pkg::SLDD_GAP;
            end else begin
              sdata_reg <= shreg_reg[STAGES-1];
              shreg_reg <= shreg_reg << 1;
              state_reg <= sldd_pkg::SLDD_LOW;
            end
          end
        end
        sldd_pkg::SLDD_GAP: begin
          if (tmr_reg > 1) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            strobe_reg <= 1'b1;
            tmr_reg <= STRB;
            state_reg <= sldd_pkg::SLDD_STROBE;
          end
        end
        sldd_pkg::SLDD_STROBE: begin
          if (tmr_reg > 1) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            // Back to idle; a queued frame is popped on the next edge.
            strobe_reg <= 1'b0;
            state_reg <= sldd_pkg::SLDD_IDLE;
          end
        end
        default: state_reg <= sldd_pkg::SLDD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every link pin comes straight from a flop, so the driver never sees a glitch.
  assign link.serial_data = sdata_reg;
  assign link.serial_clk = sclk_reg;
  assign link.latch_strobe = strobe_reg;
  assign link.output_clear = ctrl_reg[sldd_pkg::SLDD_CTRL_CLEAR_BIT];
  assign link.all_on_test = ctrl_reg[sldd_pkg::SLDD_CTRL_TEST_BIT];

endmodule : sldd_host

`default_nettype wire

// file: dv/serial_in_latched_display_driver_tb_top.sv
// Self-checking bench for the host controller and display driver pair.
`default_nettype none

module serial_in_latched_display_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [sldd_pkg::SLDD_ADDR_W-1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [47:0] driver_outputs;
  logic [31:0] v;
  int mismatches = 0;
  int num_checks = 0;

  sldd_if link ();
  sldd_host u_sldd_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  sldd_driver u_sldd_driver (.clk(clk), .rst_n(rst_n), .link(link),
    .driver_outputs(driver_outputs));
  sldd_properties u_props (.clk(clk), .rst_n(rst_n), .serial_data(link.serial_data),
    .serial_clk(link.serial_clk), .latch_strobe(link.latch_strobe),
    .output_clear(link.output_clear), .all_on_test(link.all_on_test),
    .serial_out(link.serial_out));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic push(input logic [47:0] f);
    wr_reg(sldd_pkg::SLDD_REG_FRAME_LO, f[31:0]);
    wr_reg(sldd_pkg::SLDD_REG_FRAME_HI, {16'h0000, f[47:32]});
  endtask
  // Polls status until the FIFO is empty and the sequencer is idle.
  task automatic wait_idle();
    repeat (4) @(posedge clk);
    v = 32'h0000_0000;
    for (int i = 0; i < 20000 && !(v[2] === 1'b1 && v[0] === 1'b0); i++) begin
      rd_reg(sldd_pkg::SLDD_REG_STATUS);
    end
    chk("idle", 48'h1, {47'h0, v[2] & ~v[0]});
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("outputs at reset", 48'h0, driver_outputs);
    rd_reg(sldd_pkg::SLDD_REG_CTRL);
    chk("ctrl at reset", 48'h1, {16'h0000, v});
    $display("t_reset done");
  endtask
  task automatic t_frames();
    logic [47:0] f [2];
    f = '{48'hA5C3_0F1E_8001, 48'h5A3C_F0E1_7FFE};
    wr_reg(sldd_pkg::SLDD_REG_CTRL, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      push(f[i]);
      wait_idle();
      chk("frame outputs", f[i], driver_outputs);
      rd_reg(sldd_pkg::SLDD_REG_STATUS);
      chk("serial out", {47'h0, f[i][47]}, {47'h0, v[3]});
    end
    $display("t_frames done");
  endtask
  task automatic t_hold();
    push(48'h0123_4567_89AB);
    repeat (1200) @(posedge clk);
    chk("held outputs", 48'h5A3C_F0E1_7FFE, driver_outputs);
    wait_idle();
    chk("new outputs", 48'h0123_4567_89AB, driver_outputs);
    $display("t_hold done");
  endtask
  task automatic t_gating();
    logic [31:0] c [4];
    logic [47:0] e [4];
    c = '{32'h2, 32'h3, 32'h1, 32'h0};
    e = '{48'hFFFF_FFFF_FFFF, 48'h0, 48'h0, 48'h0123_4567_89AB};
    for (int i = 0; i < 4; i++) begin
      wr_reg(sldd_pkg::SLDD_REG_CTRL, c[i]);
      repeat (8) @(posedge clk);
      chk("gated outputs", e[i], driver_outputs);
    end
    $display("t_gating done");
  endtask
  task automatic t_fifo();
    for (int i = 1; i <= 9; i++) begin
      push({12{i[3:0]}});
    end
    rd_reg(sldd_pkg::SLDD_REG_STATUS);
    chk("fifo full", 48'h1, {47'h0, v[1]});
    push(48'hFFFF_0000_FFFF);
    wait_idle();
    chk("last kept frame", {12{4'h9}}, driver_outputs);
    $display("t_fifo done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_frames();
    t_hold();
    t_gating();
    t_fifo();
    finish_test();
  end
endmodule : serial_in_latched_display_driver_tb_top

`default_nettype wire

// file: dv/sldd_properties.sv
// Concurrent checks on the pin link between host controller and driver.
`default_nettype none

module sldd_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_data,
  input wire logic serial_clk,
  input wire logic latch_strobe,
  input wire logic output_clear,
  input wire logic all_on_test,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [7:0] hold_cnt;
  logic [6:0] rise_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the serial clock last changed, and rises seen since the last strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      hold_cnt <= 8'h00;
    end else begin
      sclk_q <= serial_clk;
      hold_cnt <= (serial_clk != sclk_q) ? 8'h00 : hold_cnt + {7'h00, hold_cnt != 8'hFF};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 7'h00;
    end else if (latch_strobe) begin
      rise_cnt <= 7'h00;
    end else if (serial_clk && !sclk_q) begin
      rise_cnt <= rise_cnt + 7'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_strobe_clk_low: assert property (latch_strobe |-> !serial_clk)
    else $error("serial clock high during strobe");
  a_sclk_half_min: assert property ((serial_clk != sclk_q) |-> hold_cnt >= 8'h18)
    else $error("serial clock phase too short");
  a_data_steady_high: assert property (serial_clk |-> $stable(serial_data))
    else $error("serial data moved while clock high");
  a_strobe_width: assert property ($rose(latch_strobe) |->
    latch_strobe [*8] ##1 latch_strobe [*5] ##1 !latch_strobe)
    else $error("strobe width wrong");
  a_strobe_after_gap: assert property ($rose(latch_strobe) |-> hold_cnt >= 8'h14)
    else $error("strobe too soon after clock");
  a_frame_bit_count: assert property ($rose(latch_strobe) |-> rise_cnt == 7'h30)
    else $error("frame not 48 clock rises");
  a_out_moves_high: assert property ($changed(serial_out) |-> serial_clk)
    else $error("serial out moved outside clock high");
  a_clk_rest_strobe: assert property ($fell(latch_strobe) |-> !serial_clk [*8])
    else $error("clock too soon after strobe");
endmodule : sldd_properties

`default_nettype wire

// file: inc/sldd_if.sv
// Pin-level link between the host controller and the display driver.
`default_nettype none

interface sldd_if;
  logic serial_data;
  logic serial_clk;
  logic latch_strobe;
  logic output_clear;
  logic all_on_test;
  logic serial_out;

  modport host (
    output serial_data,
    output serial_clk,
    output latch_strobe,
    output output_clear,
    output all_on_test,
    input serial_out
  );

  modport device (
    input serial_data,
    input serial_clk,
    input latch_strobe,
    input output_clear,
    input all_on_test,
    output serial_out
  );
endinterface : sldd_if

`default_nettype wire

// file: inc/sldd_pkg.sv
// Shared constants for the serial-in latched display driver and its host controller.
`default_nettype none

package sldd_pkg;

  localparam int SLDD_STAGES = 48;
  localparam int SLDD_CLK_MHZ = 250;
  localparam int SLDD_SCLK_MAX_KHZ = 5000;
  // Half period of the serial clock in system cycles, rounded up to stay at or below max.
  localparam int SLDD_SCLK_HALF_CYC =
    (SLDD_CLK_MHZ * 1000 + 2 * SLDD_SCLK_MAX_KHZ - 1) / (2 * SLDD_SCLK_MAX_KHZ);
  // Strobe high time: 50 ns least, at 4 ns per cycle.
  localparam int SLDD_STROBE_NS = 50;
  localparam int SLDD_STROBE_CYC = (SLDD_STROBE_NS * SLDD_CLK_MHZ + 999) / 1000;
  localparam int SLDD_FIFO_DEPTH = 8;
  localparam int SLDD_ADDR_W = 2;
  localparam logic [1:0] SLDD_REG_FRAME_LO = 2'h0;
  localparam logic [1:0] SLDD_REG_FRAME_HI = 2'h1;
  localparam logic [1:0] SLDD_REG_CTRL = 2'h2;
  localparam logic [1:0] SLDD_REG_STATUS = 2'h3;
  localparam int SLDD_CTRL_CLEAR_BIT = 0;
  localparam int SLDD_CTRL_TEST_BIT = 1;
  localparam int SLDD_STAT_BUSY_BIT = 0;
  localparam int SLDD_STAT_FULL_BIT = 1;
  localparam int SLDD_STAT_EMPTY_BIT = 2;
  localparam int SLDD_STAT_SOUT_BIT = 3;
  localparam logic [31:0] SLDD_CTRL_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    SLDD_IDLE,
    SLDD_LOW,
    SLDD_HIGH,
    SLDD_STROBE,
    SLDD_GAP
  } sldd_state_t;

endpackage : sldd_pkg

`default_nettype wire
